/* File: cpu_prog_model.sv */
// program model: sfr writes and the indirect pointer
// assumes strobes are sampled on the rising edge
`timescale 1ns/10ps
module cpu_prog_model (
    input  wire logic sys_clk,
    output logic      nv_addr_wr,
    output logic      nv_data_wr,
    output logic      indirect_wr,
    output logic [7:0] cpu_wdata,
    output logic [7:0] pointer_low_byte,
    output logic [7:0] pointer_high_byte
);
    logic global_irq_enable = 1'b1;
    initial begin
        {nv_addr_wr, nv_data_wr, indirect_wr} = 3'h0;
        cpu_wdata = 8'h00;
        {pointer_high_byte, pointer_low_byte} = 16'h0000;
    end
    // one instruction; k is {addr, data, indirect}
    task automatic sfr(input logic [2:0] k, input logic [7:0] v);
        @(posedge sys_clk);
        {nv_addr_wr, nv_data_wr, indirect_wr} <= k;
        cpu_wdata <= v;
        @(posedge sys_clk);
        {nv_addr_wr, nv_data_wr, indirect_wr} <= 3'h0;
        cpu_wdata <= ~v;
    endtask
    task automatic point(input logic [7:0] hi);
        @(posedge sys_clk);
        pointer_low_byte <= 8'h40;
        pointer_high_byte <= hi;
    endtask
    task automatic write(input logic [6:0] a, input logic [7:0] d);
        sfr(3'h4, {1'b0, a});
        sfr(3'h2, d);
        point(8'h01);
        global_irq_enable = 1'b0;
        // start in the very next instruction
        @(posedge sys_clk);
        indirect_wr <= 1'b1;
        cpu_wdata   <= 8'h08;
        @(posedge sys_clk);
        cpu_wdata   <= 8'h0C;
        @(posedge sys_clk);
        indirect_wr <= 1'b0;
        cpu_wdata   <= 8'hF3;
        global_irq_enable = 1'b1;
    endtask
    task automatic read(input logic [6:0] a);
        sfr(3'h4, {1'b0, a});
        point(8'h01);
        sfr(3'h1, 8'h02);
        sfr(3'h1, 8'h03);
    endtask
    task automatic close();
        sfr(3'h1, 8'h00);
        point(8'h00);
    endtask
endmodule

/* File: data_eeprom_access_sequencer.sv */
// data eeprom control: address, data and control registers
// reached from a cpu register port; array lives in nv_array
// assumes strobes and clock_stop come from logic on sys_clk
`timescale 1ns/10ps
`include "nv_seq_map.svh"
module data_eeprom_access_sequencer
    import nv_seq_pkg::*;
#(
    parameter int ADDR_W      = 7,
    parameter int CLK_MHZ     = 25,
    parameter int WRITE_TICKS = `WRITE_TIME_US * CLK_MHZ
) (
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    input  wire logic              nv_addr_wr,
    input  wire logic              nv_data_wr,
    input  wire logic              indirect_wr,
    input  wire logic [7:0]        cpu_wdata,
    input  wire logic [7:0]        pointer_low_byte,
    input  wire logic [7:0]        pointer_high_byte,
    input  wire logic              clock_stop,
    input  wire logic              write_done_clr,
    input  wire logic              mf_flag_clr,
    output logic      [ADDR_W-1:0] nv_addr_reg,
    output logic      [7:0]        nv_data_reg,
    output logic      [7:0]        nv_ctrl_reg,
    output logic                   ctrl_selected,
    output logic                   write_done_flag,
    output logic                   mf_irq_flag,
    output logic                   busy
);
    localparam int CNT_W = $clog2(WRITE_TICKS + 1);
    localparam logic [CNT_W-1:0] WR_LAST = CNT_W'(WRITE_TICKS - 1);
    localparam logic [CNT_W-1:0] RD_LAST = CNT_W'(`READ_CYCLES - 1);

    logic       rst_meta;
    logic       rst_sync;
    logic [7:0] rd_data;
    logic [3:0] ctrl;
    logic [3:0] next_ctrl;
    logic [ADDR_W-1:0] next_addr;
    logic [7:0] next_data;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    seq_state_t state;
    seq_state_t next_state;
    logic       next_done;
    logic       next_mf;
    logic       ctrl_wr;
    logic       arr_wr;
    logic       cycle_end;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    assign ctrl_selected = (pointer_low_byte == `CTRL_OFFSET) &&
                           (pointer_high_byte == `CTRL_SECTOR);
    assign ctrl_wr   = indirect_wr && ctrl_selected;
    assign nv_ctrl_reg = {4'h0, ctrl};
    assign busy      = (state != ST_IDLE);
    assign cycle_end = (cnt == ((state == ST_WRITE) ? WR_LAST : RD_LAST));
    assign arr_wr    = (state == ST_WRITE) && cycle_end && !clock_stop;

    always_comb begin
        next_ctrl  = ctrl;
        next_state = state;
        next_cnt   = cnt;
        next_addr  = nv_addr_reg;
        // operands frozen mid-cycle so the array sees stable values
        if (nv_addr_wr && !busy) begin
            next_addr = cpu_wdata[ADDR_W-1:0];
        end
        if (ctrl_wr) begin
            next_ctrl[`BIT_WRITE_ENABLE] = cpu_wdata[`BIT_WRITE_ENABLE];
            next_ctrl[`BIT_READ_ENABLE]  = cpu_wdata[`BIT_READ_ENABLE];
            // start bits cannot be dropped by software mid-cycle
            next_ctrl[`BIT_WRITE_START] = ctrl[`BIT_WRITE_START];
            next_ctrl[`BIT_READ_START]  = ctrl[`BIT_READ_START];
            // starts gated by previously set enables
            // a double start keeps only the write when write is enabled, else the read
            if (state == ST_IDLE) begin
                if (cpu_wdata[`BIT_WRITE_START] &&
                    ctrl[`BIT_WRITE_ENABLE]) begin
                    next_ctrl[`BIT_WRITE_START] = 1'b1;
                    next_state = ST_WRITE;
                    next_cnt   = '0;
                end else if (cpu_wdata[`BIT_READ_START] &&
                             ctrl[`BIT_READ_ENABLE]) begin
                    next_ctrl[`BIT_READ_START] = 1'b1;
                    next_state = ST_READ;
                    next_cnt   = '0;
                end
            end
        end
        unique case (state)
            ST_IDLE: begin
            end
            ST_READ, ST_WRITE: begin
                if (clock_stop) begin
                    next_state = ST_IDLE;
                    next_ctrl[`BIT_WRITE_START] = 1'b0;
                    next_ctrl[`BIT_READ_START]  = 1'b0;
                end else if (cycle_end) begin
                    next_state = ST_IDLE;
                    next_ctrl[`BIT_WRITE_START] = 1'b0;
                    next_ctrl[`BIT_READ_START]  = 1'b0;
                end else begin
                    next_cnt = CNT_W'(cnt + 1'b1);
                end
            end
            default: begin
                // unused state code falls back to idle
                next_state = ST_IDLE;
            end
        endcase
    end

    // flags set on write end, set beats clear
    // interrupt service clears only the multi-function flag
    always_comb begin
        next_done = write_done_flag;
        next_mf   = mf_irq_flag;
        if (write_done_clr) begin
            next_done = 1'b0;
        end
        if (mf_flag_clr) begin
            next_mf = 1'b0;
        end
        if (arr_wr) begin
            next_done = 1'b1;
            next_mf   = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            write_done_flag <= 1'b0;
            mf_irq_flag     <= 1'b0;
        end else begin
            write_done_flag <= next_done;
            mf_irq_flag     <= next_mf;
        end
    end

    // read data lands one cycle after array latch; hold until next op
    logic rd_land;
    logic next_rd_land;
    assign next_rd_land = (state == ST_READ) && cycle_end && !clock_stop;

    // data register: cpu write, or array result after a read
    always_comb begin
        next_data = nv_data_reg;
        if (nv_data_wr && !busy) begin
            next_data = cpu_wdata;
        end
        // array result beats a cpu load in the same cycle
        if (rd_land) begin
            next_data = rd_data;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            ctrl        <= `CTRL_RESET;
            state       <= ST_IDLE;
            cnt         <= '0;
            nv_addr_reg <= `ADDR_RESET;
            nv_data_reg <= `DATA_RESET;
            rd_land     <= 1'b0;
        end else begin
            ctrl        <= next_ctrl;
            state       <= next_state;
            cnt         <= next_cnt;
            nv_addr_reg <= next_addr;
            nv_data_reg <= next_data;
            rd_land     <= next_rd_land;
        end
    end

    nv_array #(
        .ADDR_W (ADDR_W)
    ) u_array (
        .sys_clk (sys_clk),
        .wr_en   (arr_wr),
        .addr    (nv_addr_reg),
        .wr_data (nv_data_reg),
        .rd_data (rd_data)
    );
endmodule

/* File: data_eeprom_access_sequencer_monitor.sv */
// port assertions for the eeprom sequencer
// assumes a write timer of about 20 cycles
`timescale 1ns/10ps
module data_eeprom_access_sequencer_monitor #(
    parameter int ADDR_W = 7
) (
    input wire logic              sys_clk,
    input wire logic              rst_n,
    input wire logic              nv_addr_wr,
    input wire logic              nv_data_wr,
    input wire logic [7:0]        cpu_wdata,
    input wire logic              clock_stop,
    input wire logic [ADDR_W-1:0] nv_addr_reg,
    input wire logic [7:0]        nv_data_reg,
    input wire logic [7:0]        nv_ctrl_reg,
    input wire logic              write_done_flag,
    input wire logic              mf_irq_flag,
    input wire logic              busy
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wen_guard_a:
    assert property ($rose(nv_ctrl_reg[2]) |-> $past(nv_ctrl_reg[3]))
        else $error("write start without enable");
    ren_guard_a:
    assert property ($rose(nv_ctrl_reg[0]) |-> $past(nv_ctrl_reg[1]))
        else $error("read start without enable");
    read_end_a:
    assert property ($rose(nv_ctrl_reg[0]) |-> ##[1:6] !nv_ctrl_reg[0])
        else $error("read never ends");
    write_end_a:
    assert property ($rose(nv_ctrl_reg[2]) |-> ##[1:24] !nv_ctrl_reg[2])
        else $error("write never ends");
    stop_abort_a:
    assert property (clock_stop && busy |-> ##[1:2] !busy)
        else $error("no abort");
    done_flag_a:
    assert property ($fell(nv_ctrl_reg[2]) && !$past(clock_stop) |->
        write_done_flag && mf_irq_flag) else $error("flags not set");
    data_hold_a:
    assert property ($changed(nv_data_reg) |-> $past(nv_data_wr) ||
        $past(busy) || $past(busy, 2)) else $error("data changed");
    addr_load_a:
    assert property (nv_addr_wr && !busy |=> nv_addr_reg ==
        $past(cpu_wdata[ADDR_W-1:0])) else $error("addr not loaded");
    cover property ($fell(nv_ctrl_reg[2]) && write_done_flag);
    cover property ($fell(nv_ctrl_reg[0]));
    cover property (clock_stop && busy);
endmodule
bind data_eeprom_access_sequencer data_eeprom_access_sequencer_monitor
    #(.ADDR_W(ADDR_W)) mon (.*);

/* File: nv_array.sv */
// nonvolatile byte array model with registered read data
// assumes one access per cycle from the sequencer
`timescale 1ns/10ps
module nv_array #(
    parameter int ADDR_W = 7
) (
    input  wire logic              sys_clk,
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [7:0]        wr_data,
    output logic      [7:0]        rd_data
);
    logic [7:0] mem [0:(1<<ADDR_W)-1];

    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[addr] <= wr_data;
        end
        rd_data <= mem[addr];
    end
endmodule

/* File: nv_seq_map.svh */
// offsets, field positions, reset values and timing counts
// assumes inclusion by the sequencer design file
`ifndef NV_SEQ_MAP_SVH
`define NV_SEQ_MAP_SVH
`define CTRL_OFFSET      8'h40
`define CTRL_SECTOR      8'h01
`define BIT_READ_START   0
`define BIT_READ_ENABLE  1
`define BIT_WRITE_START  2
`define BIT_WRITE_ENABLE 3
`define CTRL_RESET       4'h0
`define ADDR_RESET       7'h00
`define DATA_RESET       8'h00
`define WRITE_TIME_US    2000
`define READ_CYCLES      4
`endif

/* File: nv_seq_pkg.sv */
// types shared by the sequencer
// assumes no surroundings
package nv_seq_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_READ,
        ST_WRITE
    } seq_state_t;
endpackage

/* File: tb_data_eeprom_access_sequencer.sv */
// self-checking bench for the eeprom sequencer
// assumes cpu_prog_model drives the register side
`timescale 1ns/10ps
module tb_data_eeprom_access_sequencer;
    logic sys_clk = 1'b0, rst_n = 1'b0, clock_stop = 1'b0;
    logic write_done_clr = 1'b0, mf_flag_clr = 1'b0;
    logic nv_addr_wr, nv_data_wr, indirect_wr, ctrl_selected;
    logic write_done_flag, mf_irq_flag, busy;
    logic [7:0] cpu_wdata, pointer_low_byte, pointer_high_byte;
    logic [7:0] nv_data_reg, nv_ctrl_reg;
    logic [6:0] nv_addr_reg;
    int fails = 0, checked = 0, cycles = 0;
    always #20 sys_clk = ~sys_clk;
    cpu_prog_model cpu (.*);
    data_eeprom_access_sequencer #(.WRITE_TICKS(20)) uut (.*);
    task automatic chk(input logic [7:0] got, exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("fails %0d checked %0d", fails, checked);
        if (fails == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            test_done();
        end
    end
    task automatic wait_idle();
        repeat (40) if (busy === 1'b1) @(negedge sys_clk);
    endtask
    task automatic clr(input logic [1:0] k);
        @(posedge sys_clk) {write_done_clr, mf_flag_clr} <= k;
        @(posedge sys_clk) {write_done_clr, mf_flag_clr} <= 2'h0;
        @(negedge sys_clk);
    endtask
    task automatic t_guard();
        cpu.point(8'h00);
        cpu.sfr(3'h1, 8'h08);
        @(negedge sys_clk);
        chk(nv_ctrl_reg, 8'h00);
        chk(ctrl_selected, 8'h00);
        cpu.point(8'h01);
        cpu.sfr(3'h1, 8'h05);
        @(negedge sys_clk);
        chk(ctrl_selected, 8'h01);
        chk(nv_ctrl_reg, 8'h00);
        $display("guard test done");
    endtask
    task automatic t_write(input logic [6:0] a, input logic [7:0] d);
        cpu.write(a, d);
        @(negedge sys_clk);
        chk(nv_ctrl_reg, 8'h0C);
        repeat (15) @(negedge sys_clk);
        chk(busy, 8'h01);
        wait_idle();
        chk(nv_ctrl_reg, 8'h08);
        chk({write_done_flag, mf_irq_flag}, 8'h03);
        cpu.close();
        clr(2'h2);
        chk({write_done_flag, mf_irq_flag}, 8'h01);
        clr(2'h1);
        chk(mf_irq_flag, 8'h00);
        $display("write test done");
    endtask
    task automatic t_read(input logic [6:0] a, input logic [7:0] e);
        cpu.read(a);
        @(negedge sys_clk);
        chk(nv_ctrl_reg, 8'h03);
        wait_idle();
        @(negedge sys_clk);
        chk(nv_ctrl_reg, 8'h02);
        chk(nv_data_reg, e);
        cpu.close();
        $display("read test done");
    endtask
    task automatic t_abort();
        cpu.write(7'h05, 8'h5A);
        @(posedge sys_clk) clock_stop <= 1'b1;
        @(posedge sys_clk) clock_stop <= 1'b0;
        repeat (2) @(negedge sys_clk);
        chk({busy, write_done_flag}, 8'h00);
        cpu.close();
        t_read(7'h05, 8'hA5);
        $display("abort test done");
    endtask
    initial begin
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(negedge sys_clk);
        chk(nv_ctrl_reg, 8'h00);
        chk({1'b0, nv_addr_reg} | nv_data_reg, 8'h00);
        t_guard();
        t_write(7'h05, 8'hA5);
        t_write(7'h7F, 8'h3C);
        t_read(7'h05, 8'hA5);
        t_read(7'h7F, 8'h3C);
        t_abort();
        test_done();
    end
endmodule
